// ==== tid_pkg.sv ====
/*
 * Package for the test-port instruction decoder: instruction codes,
 * register widths, capture constants and the structs that carry the
 * port state. Assumes nothing of its surroundings.
 */
package tid_pkg;

    // ==========================================================
    // Widths
    localparam int TID_IR_W = 4;
    localparam int TID_SEL_W = 4;
    localparam int TID_ID_W = 32;

    // ==========================================================
    // Instruction codes
    localparam logic [3:0] TID_EXTEST = 4'h0;
    localparam logic [3:0] TID_CHAIN_SEL = 4'h2;
    localparam logic [3:0] TID_SAMPLE = 4'h3;
    localparam logic [3:0] TID_RESTART = 4'h4;
    localparam logic [3:0] TID_CLAMP = 4'h5;
    localparam logic [3:0] TID_TRISTATE_INDICATOR_OUT = 4'h7;
    localparam logic [3:0] TID_CLAMPZ = 4'h9;
    localparam logic [3:0] TID_INTEST = 4'hc;
    localparam logic [3:0] TID_IDCODE = 4'he;
    localparam logic [3:0] TID_BYPASS = 4'hf;

    // ==========================================================
    // Capture and reset values
    localparam logic [3:0] TID_IR_CAPTURE = 4'h1;
    localparam logic [3:0] TID_SEL_CAPTURE = 4'h8;
    localparam logic [3:0] TID_SEL_RESET = 4'h3;
    localparam logic TID_BYP_CAPTURE = 1'b0;

    // Identification code; the value is arbitrary
    localparam logic [31:0] TID_ID_VALUE = 32'h0000_0001;

    // ==========================================================
    // Controller states
    typedef enum logic [3:0] {
        TID_RESET, TID_IDLE, TID_SEL_DR, TID_CAP_DR, TID_SHIFT_DR, TID_EXIT1_DR,
        TID_PAUSE_DR, TID_EXIT2_DR, TID_UPD_DR, TID_SEL_IR, TID_CAP_IR,
        TID_SHIFT_IR, TID_EXIT1_IR, TID_PAUSE_IR, TID_EXIT2_IR, TID_UPD_IR
    } tid_state_t;

    // Strobes handed from the controller to the decoder
    typedef struct packed {
        logic capture_dr;
        logic shift_dr;
        logic update_dr;
        logic capture_ir;
        logic shift_ir;
        logic update_ir;
        logic idle_entry;
    } tid_strobe_t;

    // Scan-cell and bus control handed to the core
    typedef struct packed {
        logic chain_test_mode;
        logic chain_capture;
        logic chain_shift;
        logic chain_update;
        logic clamp_hold;
        logic bus_tristate_enable;
        logic tristate_indicator_out;
        logic outputs_inactive;
    } tid_ctrl_t;

endpackage : tid_pkg

// ==== tid_tap_fsm.sv ====
/*
 * Test-port controller state machine, advanced once per rising test
 * clock edge that the parent detects. Assumes mode select is already
 * synchronised and sampled by the parent on that edge.
 */
`timescale 1ns/100ps
module tid_tap_fsm
    import tid_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic tck_rise,
    input wire logic tms,
    output tid_state_t state
);

    typedef struct packed {
        tid_state_t state;
    } tid_fsm_reg_t;

    tid_fsm_reg_t cur;
    tid_fsm_reg_t next_cur;

    always_comb begin
        next_cur = cur;
        if (tck_rise) begin
            case (cur.state)
                TID_RESET: next_cur.state = tms ? TID_RESET : TID_IDLE;
                TID_IDLE: next_cur.state = tms ? TID_SEL_DR : TID_IDLE;
                TID_SEL_DR: next_cur.state = tms ? TID_SEL_IR : TID_CAP_DR;
                TID_CAP_DR: next_cur.state = tms ? TID_EXIT1_DR : TID_SHIFT_DR;
                TID_SHIFT_DR: next_cur.state = tms ? TID_EXIT1_DR : TID_SHIFT_DR;
                TID_EXIT1_DR: next_cur.state = tms ? TID_UPD_DR : TID_PAUSE_DR;
                TID_PAUSE_DR: next_cur.state = tms ? TID_EXIT2_DR : TID_PAUSE_DR;
                TID_EXIT2_DR: next_cur.state = tms ? TID_UPD_DR : TID_SHIFT_DR;
                TID_UPD_DR: next_cur.state = tms ? TID_SEL_DR : TID_IDLE;
                TID_SEL_IR: next_cur.state = tms ? TID_RESET : TID_CAP_IR;
                TID_CAP_IR: next_cur.state = tms ? TID_EXIT1_IR : TID_SHIFT_IR;
                TID_SHIFT_IR: next_cur.state = tms ? TID_EXIT1_IR : TID_SHIFT_IR;
                TID_EXIT1_IR: next_cur.state = tms ? TID_UPD_IR : TID_PAUSE_IR;
                TID_PAUSE_IR: next_cur.state = tms ? TID_EXIT2_IR : TID_PAUSE_IR;
                TID_EXIT2_IR: next_cur.state = tms ? TID_UPD_IR : TID_SHIFT_IR;
                TID_UPD_IR: next_cur.state = tms ? TID_SEL_DR : TID_IDLE;
                default: next_cur.state = TID_RESET;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cur.state <= TID_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    assign state = cur.state;

endmodule : tid_tap_fsm

// ==== tid_decoder.sv ====
/*
 * Instruction register and public-instruction decoder of the test port.
 * Samples the test clock, data and mode pins with the system clock,
 * decodes the current instruction and routes the serial path.
 * Assumes the system clock runs much faster than the test clock and that
 * the scan chains outside return their serial output on chain_tdo.
 */
// What this block does
// - Instruction register is exactly four bits, no parity bit.
// - Capture-IR loads 0001 into the instruction shift stage.
// - Instruction bits shift least significant bit first, in and out.
// - Data and mode sampled on rising test clock; output changes on falling.
// - EXTEST 0000 routes selected chain, test mode, captures system values.
// - EXTEST shift-DR shifts out capture, new data drives logic at once.
// - Code 0010 connects chain-select register, capturing 1000.
// - Chain number shifted in; update-DR makes it the active chain.
// - Reset selects scan chain 3.
// - Chain-select register is four bits, least significant bit first.
// - Restart 0100 connects bypass and otherwise acts as bypass.
// - Under restart, entering run-test-idle leaves debug state.
// - CLAMP 0101 connects bypass, holds scan outputs at loaded values.
// - TRISTATE_INDICATOR_OUT 0111 connects bypass, tri-states bus, drives indicator high.
// - CLAMPZ 1001 connects bypass, makes three-state outputs inactive.
// - Bypass captures zero, delays one test clock, update leaves it.
// - INTEST 1100 routes selected chain in test mode for single-step.
// - IDCODE 1110 connects 32-bit ID register, captures and shifts it.
// - BYPASS 1111 and every unlisted code except 0011 (which routes the selected chain) connect bypass, system mode.
// - Only restart releases debug state, never bypass.
// - Test reset makes IDCODE current and forces test-logic-reset.
`timescale 1ns/100ps
module tid_decoder
    import tid_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic tck,
    input wire logic tdi,
    input wire logic tms,
    input wire logic chain_tdo,
    output logic tdo,
    output logic tdo_oe,
    output logic [3:0] instr,
    output logic [3:0] chain_sel,
    output logic chain_tdi,
    output tid_ctrl_t ctrl,
    output logic debug_exit,
    output logic in_reset
);

    // ==========================================================
    // Register state
    typedef struct packed {
        logic [1:0] tck_sync;
        logic [1:0] tdi_sync;
        logic [1:0] tms_sync;
        logic tck_prev;
        tid_state_t state_prev;
        logic [3:0] ir_shift;
        logic [3:0] ir_cur;
        logic [3:0] sel_shift;
        logic [3:0] sel_cur;
        logic byp;
        logic [31:0] id_shift;
        logic serial_bit;
        logic tdo;
        logic tdo_oe;
        logic chain_tdi;
        tid_ctrl_t ctrl;
        logic debug_exit;
        logic in_reset;
    } tid_reg_t;

    tid_reg_t cur;
    tid_reg_t next_cur;

    // ==========================================================
    // Controller
    tid_state_t state;
    logic tck_rise;
    logic tck_fall;

    assign tck_rise = cur.tck_sync[1] & ~cur.tck_prev;
    assign tck_fall = ~cur.tck_sync[1] & cur.tck_prev;

    tid_tap_fsm u_fsm (
        .clk(clk),
        .resetn(resetn),
        .tck_rise(tck_rise),
        .tms(cur.tms_sync[1]),
        .state(state)
    );

    tid_strobe_t stb;
    logic chain_path;
    logic ir_reset;

    always_comb begin
        stb.capture_dr = (state == TID_CAP_DR);
        stb.shift_dr = (state == TID_SHIFT_DR);
        stb.update_dr = (state == TID_UPD_DR);
        stb.capture_ir = (state == TID_CAP_IR);
        stb.shift_ir = (state == TID_SHIFT_IR);
        stb.update_ir = (state == TID_UPD_IR);
        stb.idle_entry = (state == TID_IDLE) && (cur.state_prev != TID_IDLE);
    end

    assign ir_reset = (state == TID_RESET);
    assign chain_path = (cur.ir_cur == TID_EXTEST) || (cur.ir_cur == TID_INTEST)
        || (cur.ir_cur == TID_SAMPLE);

    // ==========================================================
    // Next state
    always_comb begin
        next_cur = cur;
        next_cur.tck_sync = {cur.tck_sync[0], tck};
        next_cur.tdi_sync = {cur.tdi_sync[0], tdi};
        next_cur.tms_sync = {cur.tms_sync[0], tms};
        next_cur.tck_prev = cur.tck_sync[1];
        next_cur.state_prev = state;
        next_cur.debug_exit = 1'b0;
        next_cur.in_reset = ir_reset;

        if (tck_rise) begin
            // Data sampled here, acted on against the state held before the edge
            // Instruction path
            if (stb.capture_ir) begin
                next_cur.ir_shift = TID_IR_CAPTURE;
            end else if (stb.shift_ir) begin
                next_cur.ir_shift = {cur.tdi_sync[1], cur.ir_shift[3:1]};
            end
            if (stb.update_ir) begin
                next_cur.ir_cur = cur.ir_shift;
            end
            // Data paths
            if (cur.ir_cur == TID_CHAIN_SEL) begin
                if (stb.capture_dr) begin
                    next_cur.sel_shift = TID_SEL_CAPTURE;
                end else if (stb.shift_dr) begin
                    next_cur.sel_shift = {cur.tdi_sync[1], cur.sel_shift[3:1]};
                end else if (stb.update_dr) begin
                    next_cur.sel_cur = cur.sel_shift;
                end
            end else if (cur.ir_cur == TID_IDCODE) begin
                if (stb.capture_dr) begin
                    next_cur.id_shift = TID_ID_VALUE;
                end else if (stb.shift_dr) begin
                    next_cur.id_shift = {cur.tdi_sync[1], cur.id_shift[31:1]};
                end
            end else if (!chain_path) begin
                if (stb.capture_dr) begin
                    next_cur.byp = TID_BYP_CAPTURE;
                end else if (stb.shift_dr) begin
                    next_cur.byp = cur.tdi_sync[1];
                end
            end
            next_cur.chain_tdi = cur.tdi_sync[1];
        end

        // Serial bit follows the low end of the selected stage, so each fall shows
        // it before the next rise shifts; the captured bit leaves first
        if (stb.shift_ir) begin
            next_cur.serial_bit = cur.ir_shift[0];
        end else begin
            case (cur.ir_cur)
                TID_CHAIN_SEL: next_cur.serial_bit = cur.sel_shift[0];
                TID_IDCODE: next_cur.serial_bit = cur.id_shift[0];
                TID_EXTEST, TID_INTEST, TID_SAMPLE: next_cur.serial_bit = chain_tdo;
                default: next_cur.serial_bit = cur.byp;
            endcase
        end

        // Output launched on the falling test clock edge
        if (tck_fall) begin
            next_cur.tdo = cur.serial_bit;
            next_cur.tdo_oe = (state == TID_SHIFT_IR) || (state == TID_SHIFT_DR);
        end

        // Scan-cell control; the held chain only acts on chain instructions
        next_cur.ctrl.chain_test_mode = (cur.ir_cur == TID_EXTEST)
            || (cur.ir_cur == TID_INTEST);
        next_cur.ctrl.chain_capture = chain_path && stb.capture_dr && tck_rise;
        next_cur.ctrl.chain_shift = chain_path && stb.shift_dr && tck_rise;
        next_cur.ctrl.chain_update = chain_path && stb.update_dr && tck_rise;
        next_cur.ctrl.clamp_hold = (cur.ir_cur == TID_CLAMP)
            || (cur.ir_cur == TID_CLAMPZ);
        next_cur.ctrl.bus_tristate_enable = (cur.ir_cur != TID_TRISTATE_INDICATOR_OUT);
        next_cur.ctrl.tristate_indicator_out = (cur.ir_cur == TID_TRISTATE_INDICATOR_OUT);
        next_cur.ctrl.outputs_inactive = (cur.ir_cur == TID_CLAMPZ);

        // Debug exit only through restart, never plain bypass
        if (cur.ir_cur == TID_RESTART && stb.idle_entry) begin
            next_cur.debug_exit = 1'b1;
        end

        // Test-logic-reset state reloads IDCODE like the pin reset
        if (ir_reset) begin
            next_cur.ir_cur = TID_IDCODE;
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cur <= '0;
            cur.ir_cur <= TID_IDCODE;
            cur.ir_shift <= TID_IR_CAPTURE;
            cur.sel_cur <= TID_SEL_RESET;
            cur.sel_shift <= TID_SEL_CAPTURE;
            cur.ctrl.bus_tristate_enable <= 1'b1;
            cur.in_reset <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    assign tdo = cur.tdo;
    assign tdo_oe = cur.tdo_oe;
    assign instr = cur.ir_cur;
    assign chain_sel = cur.sel_cur;
    assign chain_tdi = cur.chain_tdi;
    assign ctrl = cur.ctrl;
    assign debug_exit = cur.debug_exit;
    assign in_reset = cur.in_reset;

endmodule : tid_decoder

// ==== tid_decoder_asserts.sv ====
/*
 * Concurrent checks on the ports of the test-port instruction decoder.
 * Assumes the package tid_pkg and one clk domain with resetn async low.
 */
`timescale 1ns/100ps
module tid_decoder_chk
    import tid_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic tck,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic [3:0] instr,
    input wire logic [3:0] chain_sel,
    input wire tid_ctrl_t ctrl,
    input wire logic debug_exit,
    input wire logic in_reset
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // ==========================================================
    // Decoded controls get three clocks to follow a new instruction
    chk_tristate_indicator_out_pins:
    assert property ($stable(instr)[*3] |-> ctrl.tristate_indicator_out == (instr == TID_TRISTATE_INDICATOR_OUT)
        && ctrl.bus_tristate_enable == (instr != TID_TRISTATE_INDICATOR_OUT))
        else $error("tristate controls disagree with instruction");
    chk_clampz_off:
    assert property ($stable(instr)[*3] |-> ctrl.outputs_inactive == (instr == TID_CLAMPZ))
        else $error("inactive outputs disagree with instruction");
    chk_clamp_hold:
    assert property ($stable(instr)[*3] |-> ctrl.clamp_hold
        == (instr == TID_CLAMP || instr == TID_CLAMPZ))
        else $error("clamp hold disagrees with instruction");
    chk_cell_mode:
    assert property ($stable(instr)[*3] |-> (instr == TID_EXTEST || instr == TID_INTEST)
        ? ctrl.chain_test_mode : ((instr == TID_IDCODE || instr == TID_BYPASS)
        ? !ctrl.chain_test_mode : 1'b1))
        else $error("scan cell mode wrong for instruction");

    // ==========================================================
    // Timing of the serial side
    chk_tdo_fall:
    assert property ($changed(tdo) |-> !tck && !$past(tck))
        else $error("tdo moved while test clock high");
    chk_oe_fall:
    assert property ($changed(tdo_oe) |-> !tck)
        else $error("tdo enable moved while test clock high");
    chk_shift_pulse:
    assert property (ctrl.chain_shift |=> !ctrl.chain_shift)
        else $error("chain shift strobe longer than one clock");
    chk_instr_update:
    assert property ($changed(instr) |-> !tdo_oe)
        else $error("instruction changed during a shift");
    chk_chain_update:
    assert property ($changed(chain_sel) |-> instr == TID_CHAIN_SEL && !tdo_oe)
        else $error("chain changed outside chain-select update");
    chk_tlr_idcode:
    assert property (in_reset[*3] |-> instr == TID_IDCODE && !tdo_oe)
        else $error("test-logic-reset without identification instruction");
    chk_exit_cause:
    assert property (debug_exit |-> instr == TID_RESTART ##1 !debug_exit)
        else $error("debug exit without restart or too long");

    cov_exit: cover property (debug_exit);
    cov_tristate_indicator_out: cover property (ctrl.tristate_indicator_out);
    cov_chain: cover property ($changed(chain_sel));
    cov_clampz: cover property (ctrl.outputs_inactive);
endmodule : tid_decoder_chk

bind tid_decoder tid_decoder_chk u_chk (.clk(clk), .resetn(resetn), .tck(tck), .tdo(tdo),
    .tdo_oe(tdo_oe), .instr(instr), .chain_sel(chain_sel), .ctrl(ctrl),
    .debug_exit(debug_exit), .in_reset(in_reset));

// ==== tid_host.sv ====
/*
 * Debug host model driving the test port pins.
 * Assumes the caller runs one scan at a time; the test clock idles low.
 */
`timescale 1ns/100ps
module tid_host (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // ==========================================================
    // One test clock: change at the fall, read tdo just before the rise
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #62.5;
        q = tdo;
        tck = 1'b1;
        #62.5;
        tck = 1'b0;
    endtask : step

    // Idle to idle scan; tdi toggles outside the frame so no stale bit passes
    task automatic scan(input logic ir, input logic [31:0] din, input int n,
                        output logic [31:0] dout);
        logic q;
        dout = '0;
        step(1'b1, ~tdi, q);
        if (ir) step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
        step(1'b0, ~tdi, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, ~tdi, q);
        step(1'b0, ~tdi, q);
    endtask : scan
endmodule : tid_host

// ==== tb.sv ====
/*
 * Self-checking bench for tid_decoder with the host model on its pins.
 * Assumes the checker file is compiled alongside; the scan chain is a toggler.
 */
`timescale 1ns/100ps
module tb;
    import tid_pkg::*;
    logic clk, resetn, chain_tdo, tck, tms, tdi, tdo, tdo_oe, chain_tdi, debug_exit;
    logic in_reset, q;
    logic [3:0] instr, chain_sel, v;
    tid_ctrl_t ctrl;
    logic [31:0] got, din;
    int n_fail, total_checks, n_exit, cycles, k, n_shift;

    tid_decoder u_dut (.clk(clk), .resetn(resetn), .tck(tck), .tdi(tdi), .tms(tms),
        .chain_tdo(chain_tdo), .tdo(tdo), .tdo_oe(tdo_oe), .instr(instr),
        .chain_sel(chain_sel), .chain_tdi(chain_tdi), .ctrl(ctrl),
        .debug_exit(debug_exit), .in_reset(in_reset));
    tid_host u_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

    always #5 clk = ~clk;
    always @(negedge clk) chain_tdo <= ~chain_tdo;
    always @(posedge clk) begin
        if (debug_exit === 1'b1) n_exit++;
        if (ctrl.chain_shift === 1'b1) n_shift++;
        cycles++;
        if (cycles == 60000) begin
            n_fail++;
            $display("[ERR] %0t timeout", $time);
            conclude();
        end
    end

    // ==========================================================
    // Helpers
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string what);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, g, e);
        end
    endtask : chk

    task automatic load(input logic [3:0] c);
        u_host.scan(1'b1, {28'h0, c}, 4, got);
        chk(got, 32'h1, "ir capture");
        repeat (6) @(negedge clk);
        chk(32'(instr), 32'(c), "instr");
    endtask : load

    task automatic sel_chain(input logic [3:0] n);
        load(TID_CHAIN_SEL);
        u_host.scan(1'b0, {28'h0, n}, 4, got);
        chk(got, 32'h8, "select capture");
        repeat (6) @(negedge clk);
        chk(32'(chain_sel), 32'(n), "chain");
    endtask : sel_chain

    // Clamp, bus enable, indicator, inactive
    function automatic logic [3:0] exp_ctrl(input logic [3:0] c);
        return {c == TID_CLAMP || c == TID_CLAMPZ, c != TID_TRISTATE_INDICATOR_OUT, c == TID_TRISTATE_INDICATOR_OUT, c == TID_CLAMPZ};
    endfunction : exp_ctrl

    task automatic conclude();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude

    // ==========================================================
    // Main sequence
    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        chain_tdo = 1'b0;
        void'($urandom(55566));
        repeat (3) @(negedge clk);
        chk(32'(instr), 32'(TID_IDCODE), "reset instr");
        chk(32'(chain_sel), 32'h3, "reset chain");
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        u_host.step(1'b0, 1'b0, q);
        for (int c = 0; c < 16; c++) begin
            if (c == 5) sel_chain(4'h0);
            k = n_exit;
            load(c[3:0]);
            chk(32'(n_exit - k), 32'(c == 4), "debug exit");
            chk(32'({ctrl.clamp_hold, ctrl.bus_tristate_enable, ctrl.tristate_indicator_out,
                ctrl.outputs_inactive}), 32'(exp_ctrl(c[3:0])), "ctrl");
            if (c inside {0, 12, 14, 15})
                chk(32'(ctrl.chain_test_mode), 32'(c < 13), "mode");
            din = $urandom;
            if (c == 2) begin
                sel_chain(4'h3);
            end else if (c == 0) begin
                k = n_shift;
                u_host.scan(1'b0, din, 8, got);
                chk(32'(n_shift - k), 32'd8, "chain shifts");
                chk(32'(chain_tdi), 32'(tdi), "chain tdi");
            end else if (c == 14) begin
                u_host.scan(1'b0, din, 32, got);
                chk(got, TID_ID_VALUE, "id");
            end else if (!(c inside {0, 3, 12})) begin
                u_host.scan(1'b0, din, 8, got);
                chk(got, {24'h0, din[6:0], 1'b0}, "bypass");
            end
        end
        v = 4'($urandom_range(15));
        sel_chain(v);
        load(TID_BYPASS);
        chk(32'(chain_sel), 32'(v), "chain kept");
        repeat (5) u_host.step(1'b1, 1'b0, q);
        repeat (6) @(negedge clk);
        chk(32'({in_reset, instr}), 32'({1'b1, TID_IDCODE}), "tlr");
        u_host.step(1'b0, 1'b0, q);
        load(TID_TRISTATE_INDICATOR_OUT);
        resetn = 1'b0;
        repeat (2) @(negedge clk);
        chk(32'({instr, chain_sel}), 32'({TID_IDCODE, 4'h3}), "mid reset");
        resetn = 1'b1;
        repeat (4) @(negedge clk);
        conclude();
    end
endmodule : tb
